//--- pkg/pin_mux_pkg.sv
package pin_mux_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] bus_ctrl_off = 8'h00;
  localparam logic [7:0] global_ctrl_1_off = 8'h04;
  localparam logic [7:0] global_ctrl_2_off = 8'h08;
  localparam logic [7:0] status_off = 8'h0c;

  // ==========================================================
  // field positions
  localparam int bus_holder_lo_bit = 0;
  localparam int bus_holder_hi_bit = 1;
  localparam int pull_en_bit = 2;
  localparam int clock_out_hold_tristate_bit = 0;
  localparam int stat_external_memory_interface_sel_bit = 0;
  localparam int stat_latched_bit = 1;
  localparam int stat_hold_bit = 2;
  localparam int stat_off_bit = 3;

  // ==========================================================
  // reset values
  localparam logic [2:0] bus_ctrl_rst = 3'h7;
  localparam logic global_ctrl_rst = 1'b0;

  // ==========================================================
  // timing: two synchroniser stages pass before the strap is trusted
  localparam logic [1:0] strap_settle_cnt = 2'h2;
  localparam int clk_out_div = 2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [31:0] data;
    logic drive;
  } external_memory_interface_req_s;

  typedef struct packed {
    logic [15:0] data;
    logic [15:0] drive;
  } gpio_req_s;

  typedef struct packed {
    logic [31:0] out;
    logic [31:0] oe;
  } data_pins_s;

  typedef enum logic [2:0] {
    st_reset = 3'b001,
    st_settle = 3'b010,
    st_run = 3'b100
  } latch_state_e;

endpackage : pin_mux_pkg

//--- verilog/parallel_port_data_pin_mux.sv
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module parallel_port_data_pin_mux
  import pin_mux_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic function_select_strap,
  input wire logic hold_request_n,
  input wire logic test_reset,
  input wire logic emulation_pin_zero,
  input wire logic emulation_one_off_pin,
  input wire external_memory_interface_req_s external_memory_interface_req,
  input wire gpio_req_s gpio_req,
  input wire logic [31:0] data_pin_in,
  output data_pins_s data_pins,
  output logic [31:0] external_memory_interface_rd_data,
  output logic [15:0] parallel_gp_io_in,
  output logic external_memory_interface_sel,
  output logic [1:0] memory_clock_out,
  output logic [1:0] memory_clock_out_oe,
  output logic bus_holder_en_lo,
  output logic bus_holder_en_hi,
  output logic pull_en
);

  // ==========================================================
  // pin synchronisers (first stage read only by second)
  logic [4:0] async_meta_q;
  logic [4:0] async_sync_q;
  logic [31:0] din_meta_q;
  logic [31:0] din_sync_q;

  // sync flops carry no reset: the strap must be seen live
  // at the release edge, not as a reset value
  always_ff @(posedge pclk) begin
    async_meta_q <= {function_select_strap, hold_request_n, test_reset,
                     emulation_pin_zero, emulation_one_off_pin};
    async_sync_q <= async_meta_q;
  end

  always_ff @(posedge pclk) begin
    din_meta_q <= data_pin_in;
    din_sync_q <= din_meta_q;
  end

  logic strap_s;
  logic hold_s;
  logic off_s;
  assign strap_s = async_sync_q[4];
  assign hold_s = ~async_sync_q[3];
  assign off_s = ~async_sync_q[2] & async_sync_q[1] & ~async_sync_q[0];

  // ==========================================================
  // strap latch: sampled after the synchroniser refills past release
  // the wait covers the synchroniser delay, so a strap that settles
  // late in reset still reaches the latch
  latch_state_e state_q;
  logic [1:0] settle_q;
  logic external_memory_interface_sel_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_reset;
      settle_q <= 2'h0;
    end else begin
      case (state_q)
        st_reset: begin
          state_q <= st_settle;
          settle_q <= 2'h0;
        end
        st_settle: begin
          if (settle_q == strap_settle_cnt) begin
            state_q <= st_run;
          end
          settle_q <= settle_q + 2'h1;
        end
        st_run: begin
          state_q <= st_run;
        end
        default: begin
          state_q <= st_reset;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_memory_interface_sel_q <= 1'b0;
    end else if (state_q == st_settle && settle_q == strap_settle_cnt) begin
      external_memory_interface_sel_q <= strap_s;
    end
    // no later update until next reset
  end

  logic running;
  assign running = (state_q == st_run);

  // ==========================================================
  // software registers
  logic [2:0] bus_ctrl_q;
  logic [1:0] hold_tristate_q;

  // writes land only at the edge where pready stands high
  logic wr_en;
  assign wr_en = psel & penable & pready & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_ctrl_q <= bus_ctrl_rst;
    end else if (wr_en && paddr == bus_ctrl_off) begin
      bus_ctrl_q <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_tristate_q <= {2{global_ctrl_rst}};
    end else if (wr_en && paddr == global_ctrl_1_off) begin
      hold_tristate_q[0] <= pwdata[clock_out_hold_tristate_bit];
    end else if (wr_en && paddr == global_ctrl_2_off) begin
      hold_tristate_q[1] <= pwdata[clock_out_hold_tristate_bit];
    end
  end

  // ==========================================================
  // apb slave: one wait-free access phase, error on unmapped offsets
  logic mapped;
  logic [31:0] rd_mux;
  assign mapped = (paddr == bus_ctrl_off) || (paddr == global_ctrl_1_off) ||
                  (paddr == global_ctrl_2_off) || (paddr == status_off);

  always_comb begin
    rd_mux = 32'h0;
    case (paddr)
      bus_ctrl_off: rd_mux[2:0] = bus_ctrl_q;
      global_ctrl_1_off: rd_mux[clock_out_hold_tristate_bit] =
                           hold_tristate_q[0];
      global_ctrl_2_off: rd_mux[clock_out_hold_tristate_bit] =
                           hold_tristate_q[1];
      status_off: begin
        rd_mux[stat_external_memory_interface_sel_bit] = external_memory_interface_sel_q;
        rd_mux[stat_latched_bit] = running;
        rd_mux[stat_hold_bit] = hold_s;
        rd_mux[stat_off_bit] = off_s;
      end
      default: rd_mux = 32'h0;
    endcase
  end

  // pready is a one-cycle pulse; a master that misses the edge hangs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
    end else begin
      pready <= 1'b0;
    end
  end

  // an unmapped write still gets pready, with pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= ~mapped;
    end else begin
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0 : rd_mux;
    end else begin
      prdata <= 32'h0;
    end
  end

  // ==========================================================
  // data pin drive
  data_pins_s pins_d;
  logic float_all;
  // reset and unsettled strap float
  // hold floats all 32 pins whatever function the strap chose
  assign float_all = hold_s | off_s | ~running;

  always_comb begin
    pins_d.out = 32'h0;
    pins_d.oe = 32'h0;
    if (!float_all) begin
      if (external_memory_interface_sel_q) begin
        // upper pins input until core drives
        // lower pins input until core drives
        pins_d.out = external_memory_interface_req.data;
        pins_d.oe = {32{external_memory_interface_req.drive}};
      end else begin
        pins_d.out[31:16] = gpio_req.data;
        pins_d.oe[31:16] = gpio_req.drive;
        pins_d.oe[15:0] = 16'h0;
      end
    end
  end

  // one register stage keeps pin enables glitch free
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_pins <= '0;
    end else begin
      data_pins <= pins_d;
    end
  end

  // the unused function reads 0 so stale pin levels never leak
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_memory_interface_rd_data <= 32'h0;
    end else begin
      external_memory_interface_rd_data <= external_memory_interface_sel_q ? din_sync_q : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parallel_gp_io_in <= 16'h0;
    end else begin
      parallel_gp_io_in <= external_memory_interface_sel_q ? 16'h0 : din_sync_q[31:16];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_memory_interface_sel <= 1'b0;
    end else begin
      external_memory_interface_sel <= external_memory_interface_sel_q;
    end
  end

  // ==========================================================
  // holder and pull enables, straight from bus control
  // enables are registered copies: one cycle behind a bus write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_holder_en_lo <= bus_ctrl_rst[bus_holder_lo_bit];
    end else begin
      bus_holder_en_lo <= bus_ctrl_q[bus_holder_lo_bit];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_holder_en_hi <= bus_ctrl_rst[bus_holder_hi_bit];
    end else begin
      bus_holder_en_hi <= bus_ctrl_q[bus_holder_hi_bit];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_en <= bus_ctrl_rst[pull_en_bit];
    end else begin
      pull_en <= bus_ctrl_q[pull_en_bit];
    end
  end

  // ==========================================================
  // memory clock outputs from a divide-by enable
  // a divide ratio of 2 keeps every edge on a pclk edge
  logic [$clog2(clk_out_div)-1:0] div_q;
  logic clk_tick;
  assign clk_tick = (div_q == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else if (clk_tick) begin
      div_q <= ($clog2(clk_out_div))'(clk_out_div - 1);
    end else begin
      div_q <= div_q - 1'b1;
    end
  end

  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_clk
      // the clock keeps its phase through hold; only the enable changes
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          memory_clock_out[k] <= 1'b0;
        end else if (clk_tick && external_memory_interface_sel_q) begin
          memory_clock_out[k] <= ~memory_clock_out[k];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          memory_clock_out_oe[k] <= 1'b0;
        end else begin
          memory_clock_out_oe[k] <= running & external_memory_interface_sel_q & ~off_s &
                                    ~(hold_s & hold_tristate_q[k]);
        end
      end
    end
  endgenerate

endmodule : parallel_port_data_pin_mux

//--- sim/pin_mux_monitor.sv
`timescale 1ns/1ps
module pin_mux_monitor
  import pin_mux_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic hold_request_n,
  input wire logic test_reset,
  input wire logic emulation_pin_zero,
  input wire logic emulation_one_off_pin,
  input wire data_pins_s data_pins,
  input wire logic external_memory_interface_sel,
  input wire logic [1:0] memory_clock_out,
  input wire logic [1:0] memory_clock_out_oe,
  input wire logic bus_holder_en_lo,
  input wire logic bus_holder_en_hi,
  input wire logic pull_en
);
  default clocking mc @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ====
  // two sync stages plus the pin register before pins float
  sequence hold_s;
    !hold_request_n [*5];
  endsequence
  sequence off_s;
    (!test_reset && emulation_pin_zero && !emulation_one_off_pin) [*5];
  endsequence

  // ====
  AST_RST_FLOAT: assert property (disable iff (1'b0)
    !presetn |-> data_pins.oe == '0) else $error("pins driven in reset");
  AST_LO_RESERVED: assert property (
    !external_memory_interface_sel |-> data_pins.oe[15:0] == '0)
    else $error("reserved pins driven");
  AST_SEL_KEEP: assert property (
    !$fell(external_memory_interface_sel)) else $error("select lost");
  AST_INPUTS_AFTER_RST: assert property (
    $rose(presetn) |-> (data_pins.oe == '0) [*4])
    else $error("pins not inputs after reset");
  AST_HOLD_FLOAT: assert property (
    hold_s |-> data_pins.oe == '0) else $error("pins driven in hold");
  AST_OFF_FLOAT: assert property (
    off_s |-> data_pins.oe == '0 && memory_clock_out_oe == '0)
    else $error("pins driven in off mode");
  AST_CLK_RUNS: assert property (
    external_memory_interface_sel && memory_clock_out_oe[0]
    |-> ##[1:2] $changed(memory_clock_out[0])) else $error("clock stuck");
  AST_PULLS_AT_RST: assert property (
    $rose(presetn) |-> bus_holder_en_lo && bus_holder_en_hi && pull_en)
    else $error("holders or pulls off at reset");
  AST_ERR_WITH_READY: assert property (
    pslverr |-> pready) else $error("error without ready");
endmodule : pin_mux_monitor

bind parallel_port_data_pin_mux pin_mux_monitor mon_u (.pclk, .presetn,
  .pready, .pslverr, .hold_request_n, .test_reset, .emulation_pin_zero,
  .emulation_one_off_pin, .data_pins, .external_memory_interface_sel,
  .memory_clock_out, .memory_clock_out_oe, .bus_holder_en_lo,
  .bus_holder_en_hi, .pull_en);

//--- sim/mem_dev_model.sv
`timescale 1ns/1ps
module mem_dev_model
  import pin_mux_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire data_pins_s data_pins,
  input wire logic dev_en,
  input wire logic [31:0] dev_val,
  output logic [31:0] pin_lvl
);
  logic [31:0] last_q;
  logic [31:0] far_d;
  // a released bus flips each cycle so stale data never matches
  assign far_d = dev_en ? dev_val : ~last_q;
  assign pin_lvl = (data_pins.oe & data_pins.out) | (~data_pins.oe & far_d);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_q <= 32'h0;
    end else begin
      last_q <= pin_lvl;
    end
  end
endmodule : mem_dev_model

//--- sim/parallel_port_data_pin_mux_test.sv
`timescale 1ns/1ps
module parallel_port_data_pin_mux_test;
  import pin_mux_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, dev_en;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, data_pin_in, external_memory_interface_rd_data, dev_val, rd;
  logic function_select_strap, hold_request_n, test_reset;
  logic emulation_pin_zero, emulation_one_off_pin;
  logic external_memory_interface_sel, bus_holder_en_lo;
  logic bus_holder_en_hi, pull_en;
  logic [15:0] parallel_gp_io_in;
  logic [1:0] memory_clock_out, memory_clock_out_oe;
  external_memory_interface_req_s external_memory_interface_req;
  gpio_req_s gpio_req;
  data_pins_s data_pins;
  int fail_count, comparisons, cycles;
  logic [2:0] en_bits;
  assign en_bits = {pull_en, bus_holder_en_hi, bus_holder_en_lo};

  parallel_port_data_pin_mux dut_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .function_select_strap, .hold_request_n, .test_reset,
    .emulation_pin_zero, .emulation_one_off_pin, .external_memory_interface_req, .gpio_req,
    .data_pin_in, .data_pins, .external_memory_interface_rd_data, .parallel_gp_io_in,
    .external_memory_interface_sel, .memory_clock_out,
    .memory_clock_out_oe, .bus_holder_en_lo, .bus_holder_en_hi, .pull_en);
  mem_dev_model dev_u (.pclk, .presetn, .data_pins, .dev_en, .dev_val,
    .pin_lvl(data_pin_in));

  // ====
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  // ====
  task sc_mem_boot;
    chk("sel", 32'h1, external_memory_interface_sel);
    chk("oe", 32'h0, data_pins.oe);
    chk("holders", 32'h7, en_bits);
    dev_en <= 1'h1;
    cyc(4);
    chk("external_memory_interface_rd", dev_val, external_memory_interface_rd_data);
    function_select_strap <= 1'h0;
    cyc(8);
    chk("sel_keep", 32'h1, external_memory_interface_sel);
  endtask : sc_mem_boot
  task sc_hold;
    dev_en <= 1'h0;
    external_memory_interface_req <= {32'h1234_abcd, 1'h1};
    cyc(2);
    chk("drv_oe", 32'hffff_ffff, data_pins.oe);
    chk("drv_out", 32'h1234_abcd, data_pins.out);
    hold_request_n <= 1'h0;
    cyc(5);
    chk("hold_oe", 32'h0, data_pins.oe);
    chk("clk_run", 32'h3, memory_clock_out_oe);
    apb(1'h1, global_ctrl_1_off, 32'h1);
    cyc(3);
    chk("clk0_z", 32'h2, memory_clock_out_oe);
    apb(1'h1, global_ctrl_2_off, 32'h1);
    cyc(3);
    chk("clk1_z", 32'h0, memory_clock_out_oe);
    hold_request_n <= 1'h1;
    cyc(5);
    chk("unhold", 32'hffff_ffff, data_pins.oe);
  endtask : sc_hold
  task sc_off;
    test_reset <= 1'h0;
    cyc(5);
    chk("off_oe", 32'h0, data_pins.oe);
    chk("off_clk", 32'h0, memory_clock_out_oe);
    test_reset <= 1'h1;
    cyc(5);
    chk("on_oe", 32'hffff_ffff, data_pins.oe);
  endtask : sc_off
  task sc_regs;
    apb(1'h1, bus_ctrl_off, 32'h5);
    cyc(1);
    chk("bc_bits", 32'h5, en_bits);
    apb(1'h0, bus_ctrl_off, 32'h0);
    chk("bc_rd", 32'h5, rd);
    apb(1'h0, 8'h10, 32'h0);
    chk("slverr", 32'h1, err);
    chk("unm_rd", 32'h0, rd);
  endtask : sc_regs
  task sc_gp_boot;
    presetn <= 1'h0;
    cyc(2);
    chk("rst_oe", 32'h0, data_pins.oe);
    presetn <= 1'h1;
    cyc(8);
    chk("sel_lo", 32'h0, external_memory_interface_sel);
    chk("holders", 32'h7, en_bits);
    gpio_req <= {16'h0f0f, 16'h00ff};
    dev_en <= 1'h1;
    cyc(5);
    chk("gp_oe", 32'h00ff_0000, data_pins.oe);
    chk("gp_in", {dev_val[31:24], 8'h0f}, parallel_gp_io_in);
    chk("external_memory_interface_rd0", 32'h0, external_memory_interface_rd_data);
  endtask : sc_gp_boot

  // ====
  task end_sim;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    pclk = 1'h0;
    forever #2 pclk = ~pclk;
  end
  // the whole run needs well under a thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, dev_en, emulation_one_off_pin} = '0;
    {paddr, pwdata, external_memory_interface_req, gpio_req} = '0;
    {function_select_strap, hold_request_n, test_reset} = 3'h7;
    emulation_pin_zero = 1'h1;
    dev_val = 32'hc3a5_5a3c;
    cyc(20);
    presetn <= 1'h1;
    cyc(8);
    sc_mem_boot();
    sc_hold();
    sc_off();
    sc_regs();
    sc_gp_boot();
    end_sim();
  end
endmodule : parallel_port_data_pin_mux_test
